// ===== rtl/pfrs_pkg.sv
// Purpose: Shared constants and helpers for the pipelined flash read scheduler
// Assumes: Scheduler clock is also the flash read clock (10 MHz, 100 ns period)
// Notes:   Times are kept in ns; cycle counts are derived from them
package pfrs_pkg;

  // Clock and flash timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int T_CHQV_NS      = 20;
  localparam int T_SETUP_DEF_NS = 4;
  localparam int T_PROP_DEF_NS  = 0;
  localparam int T_GHQZ_DEF_NS  = 20;

  // Widths and field positions
  localparam int CNT_W    = 4;
  localparam int LAT_W    = 3;
  localparam int LAT_MAX  = 7;
  localparam int WS_BIT   = 1;
  localparam int BYTE_BIT = 0;

  localparam logic [LAT_W-1:0] LAT_MIN     = 3'h1;
  localparam logic [CNT_W-1:0] CNT_SAT     = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;

  typedef enum logic [1:0] {
    BK_RUN,
    BK_DRAIN,
    BK_GAP
  } pfrs_bank_state_t;

  // Least time rounded up to whole clocks, never below one clock
  function automatic int pfrs_ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : pfrs_ceil_cycles

  function automatic logic [CNT_W-1:0] pfrs_max(input logic [CNT_W-1:0] a,
                                                input logic [CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction : pfrs_max

endpackage : pfrs_pkg

// ===== rtl/pfrs_addr_map.sv
// Purpose: Low address bit routing between CPU address and flash address
// Assumes: Bit 0 is the byte-select line, bit 1 the word-select line
// Notes:   Used by the read path here; writes must share it so software sees one address map
`timescale 1ns/1ps
`default_nettype none

module pfrs_addr_map
  import pfrs_pkg::*;
#(
  parameter int AW = 21
) (
  // Mode
  input  wire logic          byte_mode_i,
  // Address
  input  wire logic [AW-1:0] addr_i,
  output logic      [AW-1:0] addr_o
);

  // In byte mode the two low lines swap, so a linear byte walk toggles the
  // word-select line every access; writes must use this same map so that
  // only off-board programming needs reordered images.
  always_comb begin
    addr_o = addr_i;
    if (byte_mode_i) begin
      addr_o[BYTE_BIT] = addr_i[WS_BIT];
      addr_o[WS_BIT]   = addr_i[BYTE_BIT];
    end
  end

endmodule : pfrs_addr_map

`default_nettype wire

// ===== rtl/pfrs_sched.sv
// Purpose: Host-side read scheduler for a synchronous pipelined flash
// Assumes: Flash runs on mclk_i; latency setting changes only when idle
// Notes:   Two banks selected by the top CPU address bit; reads only
//
// Operation
// - Controller drives address valid, enables itself
// - Alternating spacing: data valid, delay, setup
// - Round alternating spacing up to clocks
// - One-clock spacing issues on next edge
// - Longer spacing inserts idle address-valid cycles
// - Same spacing: max of latency, twice alternating
// - Latency two at 33 MHz: 1-0-0-0
// - Unchanged word-select uses same spacing only
// - Same accesses latency two: two clocks apart
// - Latency three at 40 MHz: three clocks
// - Byte mode swaps two lowest address bits
// - Byte walk presents 00, 10, 01, 11
// - Writes share the same address swap
// - Bank chosen by its own chip enable
// - Drain current bank before enabling another
// - Next output enable waits output-disable time
// - Burst needs guard only past bank size
// - Pipelined accesses may cross banks anywhere
`timescale 1ns/1ps
`default_nettype none

module pfrs_sched
  import pfrs_pkg::*;
#(
  parameter int CAW        = 22,
  parameter int DW         = 16,
  parameter int T_PROP_NS  = T_PROP_DEF_NS,
  parameter int T_SETUP_NS = T_SETUP_DEF_NS,
  parameter int T_GHQZ_NS  = T_GHQZ_DEF_NS
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // Configuration
  input  wire logic             byte_mode_i,
  input  wire logic [LAT_W-1:0] read_latency_setting_i,
  // CPU request
  input  wire logic             req_valid_i,
  output logic                  req_ready_o,
  input  wire logic [CAW-1:0]   req_addr_i,
  // CPU response
  output logic                  rsp_valid_o,
  output logic      [DW-1:0]    rsp_data_o,
  // Flash pins
  output logic      [CAW-2:0]   flash_addr_o,
  output logic                  address_valid_n_o,
  output logic                  bank0_enable_n_o,
  output logic                  bank1_enable_n_o,
  output logic                  output_enable0_n_o,
  output logic                  output_enable1_n_o,
  input  wire logic [DW-1:0]    flash_data_i
);

  localparam int FAW = CAW - 1;

  // Alternating spacing from the flash data-valid time plus board terms
  localparam int ALT_CYC_I =
    pfrs_ceil_cycles(T_CHQV_NS + T_PROP_NS + T_SETUP_NS);
  localparam logic [CNT_W-1:0] ALT_CYC  = CNT_W'(ALT_CYC_I);
  localparam logic [CNT_W-1:0] GHQZ_CYC = CNT_W'(pfrs_ceil_cycles(T_GHQZ_NS));

  // Declarations
  logic [FAW-1:0]      mapped_addr;
  logic                req_bank;
  logic                req_ws;
  logic [LAT_W-1:0]    lat_eff;
  logic [CNT_W-1:0]    same_cyc;
  logic [CNT_W-1:0]    need_cyc;
  logic                issue;
  logic [LAT_MAX:0]    pend_d;
  logic                oe_on_d;

  logic [CNT_W-1:0]    since_q;
  logic                last_ws_q;
  logic [LAT_MAX:0]    pend_q;
  pfrs_bank_state_t    bstate_q;
  logic                active_bank_q;
  logic                target_bank_q;
  logic [CNT_W-1:0]    gap_cnt_q;
  logic [FAW-1:0]      flash_addr_q;
  logic                adv_n_q;
  logic                ce0_n_q;
  logic                ce1_n_q;
  logic                oe0_n_q;
  logic                oe1_n_q;
  logic                rsp_valid_q;
  logic [DW-1:0]       rsp_data_q;

  pfrs_addr_map #(
    .AW          (FAW)
  ) u_addr_map (
    .byte_mode_i (byte_mode_i),
    .addr_i      (req_addr_i[FAW-1:0]),
    .addr_o      (mapped_addr)
  );

  assign req_bank = req_addr_i[CAW-1];
  assign req_ws   = mapped_addr[WS_BIT];
  // A zero setting is not meaningful for the part; treat it as one clock
  assign lat_eff  = (read_latency_setting_i < LAT_MIN) ? LAT_MIN : read_latency_setting_i;

  // Same spacing is the larger of the latency and two alternating spacings
  always_comb begin
    same_cyc = pfrs_max(CNT_W'(lat_eff), CNT_W'(ALT_CYC << 1));
    need_cyc = (req_ws != last_ws_q) ? ALT_CYC : same_cyc;
  end

  // since_q counts clocks since the last access; idle clocks in between
  // are the stretch cycles with address valid held inactive.
  assign req_ready_o = (bstate_q == BK_RUN) && (req_bank == active_bank_q)
                       && (since_q >= need_cyc);
  assign issue       = req_valid_i && req_ready_o;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      since_q <= CNT_SAT;
    end else if (issue) begin
      since_q <= CNT_ONE;
    end else if (since_q != CNT_SAT) begin
      since_q <= since_q + CNT_ONE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      last_ws_q <= 1'b0;
    end else if (issue) begin
      last_ws_q <= req_ws;
    end
  end

  // Outstanding reads: a bit walks down from the latency slot to zero,
  // where the data beat is captured.
  always_comb begin
    pend_d = {1'b0, pend_q[LAT_MAX:1]};
    if (issue) begin
      pend_d[lat_eff] = 1'b1;
    end
    oe_on_d = (pend_d != '0);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Bank crossing guard, applied on every change since a pipelined bus
  // may bounce between banks; a burst only reaches it past a bank end.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bstate_q      <= BK_RUN;
      active_bank_q <= 1'b0;
      target_bank_q <= 1'b0;
      gap_cnt_q     <= CNT_ZERO;
    end else begin
      case (bstate_q)
        BK_RUN: begin
          if (req_valid_i && (req_bank != active_bank_q)) begin
            bstate_q      <= BK_DRAIN;
            target_bank_q <= req_bank;
          end
        end
        BK_DRAIN: begin
          if (pend_q == '0) begin
            bstate_q  <= BK_GAP;
            gap_cnt_q <= CNT_ONE;
          end
        end
        BK_GAP: begin
          if (gap_cnt_q >= GHQZ_CYC) begin
            bstate_q      <= BK_RUN;
            active_bank_q <= target_bank_q;
          end else begin
            gap_cnt_q <= gap_cnt_q + CNT_ONE;
          end
        end
        default: begin
          bstate_q <= BK_RUN;
        end
      endcase
    end
  end

  // Flash pins come straight from flops so setup to the flash clock holds
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      adv_n_q      <= 1'b1;
      flash_addr_q <= '0;
    end else begin
      adv_n_q <= !issue;
      if (issue) begin
        flash_addr_q <= mapped_addr;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ce0_n_q <= 1'b1;
      ce1_n_q <= 1'b1;
      oe0_n_q <= 1'b1;
      oe1_n_q <= 1'b1;
    end else begin
      ce0_n_q <= !(oe_on_d && !active_bank_q);
      ce1_n_q <= !(oe_on_d && active_bank_q);
      oe0_n_q <= !(oe_on_d && !active_bank_q);
      oe1_n_q <= !(oe_on_d && active_bank_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
    end else begin
      rsp_valid_q <= pend_q[0];
      if (pend_q[0]) begin
        rsp_data_q <= flash_data_i;
      end
    end
  end

  assign rsp_valid_o        = rsp_valid_q;
  assign rsp_data_o         = rsp_data_q;
  assign flash_addr_o       = flash_addr_q;
  assign address_valid_n_o  = adv_n_q;
  assign bank0_enable_n_o   = ce0_n_q;
  assign bank1_enable_n_o   = ce1_n_q;
  assign output_enable0_n_o = oe0_n_q;
  assign output_enable1_n_o = oe1_n_q;

  // Helper state watching the pins only
  logic [CNT_W-1:0] adv_gap_h;
  logic             prev_ws_h;
  logic [CNT_W-1:0] oe_off_h;
  logic             last_oe_bank_h;

  // Remembers which bank drove last, so only a true hand-over is timed
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      adv_gap_h      <= CNT_SAT;
      prev_ws_h      <= 1'b0;
      oe_off_h       <= CNT_SAT;
      last_oe_bank_h <= 1'b0;
    end else begin
      if (!output_enable0_n_o) begin
        last_oe_bank_h <= 1'b0;
      end else if (!output_enable1_n_o) begin
        last_oe_bank_h <= 1'b1;
      end
      if (!address_valid_n_o) begin
        adv_gap_h <= CNT_ONE;
        prev_ws_h <= flash_addr_o[WS_BIT];
      end else if (adv_gap_h != CNT_SAT) begin
        adv_gap_h <= adv_gap_h + CNT_ONE;
      end
      if (!output_enable0_n_o || !output_enable1_n_o) begin
        oe_off_h <= CNT_ZERO;
      end else if (oe_off_h != CNT_SAT) begin
        oe_off_h <= oe_off_h + CNT_ONE;
      end
    end
  end

  AST_ALT_SPACING: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!address_valid_n_o && flash_addr_o[WS_BIT] != prev_ws_h) |-> adv_gap_h >= ALT_CYC)
    else $error("alternating access issued too early");

  AST_SAME_SPACING: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!address_valid_n_o && flash_addr_o[WS_BIT] == prev_ws_h) |-> adv_gap_h >= same_cyc)
    else $error("same word-select access issued too early");

  AST_LAT2_DATA: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!address_valid_n_o && lat_eff == 3'h2) |-> ##3 rsp_valid_o)
    else $error("latency two beat not returned on time");

  AST_LAT3_DATA: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!address_valid_n_o && lat_eff == 3'h3) |-> ##4 rsp_valid_o)
    else $error("latency three beat not returned on time");

  AST_BYTE_SWAP: assert property (@(posedge mclk_i) disable iff (reset_i)
    (issue && byte_mode_i) |=> (flash_addr_o[WS_BIT] == $past(req_addr_i[BYTE_BIT])
      && flash_addr_o[BYTE_BIT] == $past(req_addr_i[WS_BIT]) && !address_valid_n_o))
    else $error("byte mode address swap wrong");

  AST_WORD_ADDR: assert property (@(posedge mclk_i) disable iff (reset_i)
    (issue && !byte_mode_i) |=> (flash_addr_o == $past(req_addr_i[FAW-1:0])
      && !address_valid_n_o))
    else $error("word mode address not passed through");

  AST_ONE_OE: assert property (@(posedge mclk_i) disable iff (reset_i)
    !(!output_enable0_n_o && !output_enable1_n_o))
    else $error("both bank output enables active");

  AST_OE_GAP: assert property (@(posedge mclk_i) disable iff (reset_i)
    (($fell(output_enable0_n_o) && last_oe_bank_h)
      || ($fell(output_enable1_n_o) && !last_oe_bank_h))
      |-> oe_off_h > GHQZ_CYC)
    else $error("output enable reasserted before disable time");

  AST_ADV_BANK: assert property (@(posedge mclk_i) disable iff (reset_i)
    !address_valid_n_o |-> (bank0_enable_n_o != bank1_enable_n_o))
    else $error("access without exactly one bank enable");

  AST_DRAINED: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bstate_q == BK_GAP) |-> (pend_q == '0 && output_enable0_n_o && output_enable1_n_o))
    else $error("bank switch before old bank drained");

endmodule : pfrs_sched

`default_nettype wire

// ===== bench/pfrs_flash_model.sv
// Purpose: Behavioural pipelined flash bank that faces the scheduler's flash pins
// Assumes: Clocked by mclk_i; a latency setting of 0 behaves as 1
// Notes:   Accesses spaced too closely return inverted data, as a misread part would
`timescale 1ns/1ps
`default_nettype none

module pfrs_flash_model
  import pfrs_pkg::*;
#(
  parameter logic [15:0] MARK = 16'h0000
) (
  // Clock
  input  wire logic             mclk_i,
  // Control pins
  input  wire logic             adv_n_i,
  input  wire logic             ce_n_i,
  input  wire logic             oe_n_i,
  input  wire logic [20:0]      addr_i,
  input  wire logic [LAT_W-1:0] lat_i,
  // Data pins
  output logic      [15:0]      data_o,
  output logic                  drv_n_o
);
  logic [7:0]  vld_q = 8'h00;
  logic [7:0]  bad_q = 8'h00;
  logic [15:0] dat_q [8];
  logic [3:0]  gap_q = 4'hF;
  logic        ws_q  = 1'b0;
  logic        take;
  int          lat;
  int          same;
  int          k;

  always_comb begin
    lat  = (lat_i == 3'h0) ? 1 : int'(lat_i);
    same = (lat > 2) ? lat : 2;
    k    = lat - 1;
  end

  assign take = ~adv_n_i & ~ce_n_i;

  // Slot i holds the access sampled i+1 edges ago
  always @(posedge mclk_i) begin
    vld_q    <= {vld_q[6:0], take};
    bad_q    <= {bad_q[6:0], (addr_i[1] == ws_q) ? (gap_q < same) : (gap_q < 1)};
    dat_q[0] <= addr_i[15:0] ^ MARK;
    for (int i = 1; i < 8; i++) begin
      dat_q[i] <= dat_q[i-1];
    end
    if (take) begin
      gap_q <= 4'h1;
      ws_q  <= addr_i[1];
    end else if (gap_q != 4'hF) begin
      gap_q <= gap_q + 4'h1;
    end
  end

  // A real part drives whenever enabled, with junk outside a valid beat
  assign drv_n_o = oe_n_i | ce_n_i;
  assign data_o  = (vld_q[k] & ~bad_q[k]) ? dat_q[k] : ~dat_q[k];

endmodule : pfrs_flash_model
`default_nettype wire

// ===== bench/tb.sv
// Purpose: Self-checking bench for the pipelined flash read scheduler
// Assumes: Default timing parameters, so alternating spacing is one clock
// Notes:   Access stretching needs a larger propagation delay and is not run here
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pfrs_pkg::*;
  // Output-disable time rounded to clocks, plus one idle clock
  localparam int GAP = 1 + (T_GHQZ_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  logic             mclk_i = 1'b0;
  logic             reset_i = 1'b1;
  logic             byte_mode_i = 1'b0;
  logic [LAT_W-1:0] read_latency_setting_i = 3'h2;
  logic             req_valid_i = 1'b0;
  logic [21:0]      req_addr_i = 22'h0;
  logic             req_ready_o, rsp_valid_o, address_valid_n_o;
  logic             bank0_enable_n_o, bank1_enable_n_o;
  logic             output_enable0_n_o, output_enable1_n_o;
  logic [15:0]      rsp_data_o, flash_data_i, d0, d1;
  logic [15:0]      bus_last = 16'h0;
  logic [20:0]      flash_addr_o;
  logic             drv0_n, drv1_n;
  logic [21:0]      av [4];
  logic [15:0]      rq [$];
  int               n_mismatch = 0;
  int               checks = 0;
  int               cyc = 0;
  int               gap = 0;
  int               last_bk = -1;
  int               bk;

  pfrs_sched uut (.mclk_i(mclk_i), .reset_i(reset_i), .byte_mode_i(byte_mode_i),
    .read_latency_setting_i(read_latency_setting_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_addr_i(req_addr_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .flash_addr_o(flash_addr_o),
    .address_valid_n_o(address_valid_n_o), .bank0_enable_n_o(bank0_enable_n_o),
    .bank1_enable_n_o(bank1_enable_n_o), .output_enable0_n_o(output_enable0_n_o),
    .output_enable1_n_o(output_enable1_n_o), .flash_data_i(flash_data_i));
  pfrs_flash_model #(.MARK(16'h0000)) fl0 (.mclk_i(mclk_i), .adv_n_i(address_valid_n_o),
    .ce_n_i(bank0_enable_n_o), .oe_n_i(output_enable0_n_o), .addr_i(flash_addr_o),
    .lat_i(read_latency_setting_i), .data_o(d0), .drv_n_o(drv0_n));
  pfrs_flash_model #(.MARK(16'h5A00)) fl1 (.mclk_i(mclk_i), .adv_n_i(address_valid_n_o),
    .ce_n_i(bank1_enable_n_o), .oe_n_i(output_enable1_n_o), .addr_i(flash_addr_o),
    .lat_i(read_latency_setting_i), .data_o(d1), .drv_n_o(drv1_n));

  // Released bus toggles every cycle so a stale value never looks valid
  assign flash_data_i = !drv0_n ? d0 : (!drv1_n ? d1 : ~bus_last);

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  always @(posedge mclk_i) begin
    bus_last <= flash_data_i;
    cyc++;
    if (rsp_valid_o === 1'b1) rq.push_back(rsp_data_o);
    if (!reset_i) begin
      if (output_enable0_n_o === 1'b0 && output_enable1_n_o === 1'b0) chk("oe_both", 1, 0);
      if (output_enable0_n_o === 1'b1 && output_enable1_n_o === 1'b1) begin
        gap++;
      end else begin
        bk = (output_enable0_n_o === 1'b0) ? 0 : 1;
        if (last_bk >= 0 && bk != last_bk) chk("oe_gap", 32'(gap >= GAP), 1);
        last_bk = bk;
        gap = 0;
      end
    end
  end

  function automatic logic [15:0] exp_data(input logic [21:0] a, input logic bm);
    logic [20:0] f;
    f = bm ? {a[20:2], a[0], a[1]} : a[20:0];
    return f[15:0] ^ (a[21] ? 16'h5A00 : 16'h0000);
  endfunction : exp_data

  task automatic send(input logic [21:0] a, output int t);
    logic r;
    int   n;
    req_valid_i <= 1'b1;
    req_addr_i  <= a;
    n = 0;
    do begin
      @(negedge mclk_i);
      t = cyc;
      r = req_ready_o;
      @(posedge mclk_i);
      n++;
    end while (r !== 1'b1 && n < 50);
    if (n >= 50) chk("ready_wait", 0, 1);
  endtask : send

  // Four reads from av; g is the expected accept spacing, or -1 to skip it
  task automatic seq(input logic [2:0] lat, input logic bm, input int g);
    int t [4];
    int i;
    read_latency_setting_i <= lat;
    byte_mode_i <= bm;
    rq.delete();
    @(posedge mclk_i);
    for (i = 0; i < 4; i++) send(av[i], t[i]);
    req_valid_i <= 1'b0;
    for (i = 1; i < 4; i++) if (g >= 0) chk("spacing", t[i] - t[i-1], g);
    i = 0;
    while (rq.size() < 4 && i < 100) begin
      @(posedge mclk_i);
      i++;
    end
    chk("beats", rq.size(), 4);
    if (rq.size() == 4) begin
      for (i = 0; i < 4; i++) chk("data", rq[i], exp_data(av[i], bm));
    end
  endtask : seq

  task automatic final_report();
    $display("TB: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("reset_pins", {address_valid_n_o, bank0_enable_n_o, bank1_enable_n_o,
        output_enable0_n_o, output_enable1_n_o, rsp_valid_o}, 6'h3E);
    chk("reset_addr", flash_addr_o, 0);
    @(posedge mclk_i);
    reset_i <= 1'b0;
    av = '{22'h0, 22'h2, 22'h4, 22'h6};
    seq(3'h2, 1'b0, 1);
    av = '{22'h0, 22'h8, 22'h10, 22'h18};
    for (int l = 1; l <= 4; l++) seq(3'(l), 1'b0, (l > 2) ? l : 2);
    av = '{22'h0, 22'h1, 22'h2, 22'h3};
    seq(3'h2, 1'b1, 1);
    av = '{22'h0, 22'h200002, 22'h4, 22'h200006};
    seq(3'h2, 1'b0, -1);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge mclk_i);
    n_mismatch++;
    final_report();
  end

endmodule : tb
`default_nettype wire
